//--- rtl/uart_byte_fifo.sv
// Small flip-flop FIFO for bytes with level output
`timescale 1ns/10ps
module uart_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Write side
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    // Read side
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data,
    // Status
    output logic full,
    output logic empty,
    output logic [AW:0] level
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t st, next_st;
    logic do_wr, do_rd;

    // Pointer and storage update; full blocks writes, empty blocks reads
    always_comb begin
        next_st = st;
        do_wr = wr_valid && (st.cnt != (AW+1)'(DEPTH));
        do_rd = rd_ready && (st.cnt != '0);
        if (do_wr) begin
            next_st.mem[st.wp] = wr_data;
            next_st.wp = st.wp + 1'b1;
        end
        if (do_rd) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.mem[st.rp];
    assign full = (st.cnt == (AW+1)'(DEPTH));
    assign empty = (st.cnt == '0);
    assign level = st.cnt;
endmodule // uart_byte_fifo

//--- rtl/uart_special_defines.svh
// Register offsets, field positions, reset values and timing counts for the serial core
`ifndef UART_SPECIAL_DEFINES_SVH
`define UART_SPECIAL_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_DATA 8'h00
`define OFF_CTRL 8'h04
`define OFF_BAUD 8'h08
`define OFF_LIN 8'h0C
`define OFF_RAW 8'h10
`define OFF_MASK 8'h14
`define OFF_MASKED 8'h18
`define OFF_STATUS 8'h1C
`define OFF_DMA 8'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_EN 0
`define CTRL_LIN 1
`define CTRL_IR 2
`define CTRL_SC 3
`define CTRL_PAR 4
`define CTRL_SEND_BREAK 5
`define CTRL_W 6

// ----------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_TIMEOUT 2
`define IRQ_PARITY 3
`define IRQ_BREAK_DONE 4
`define IRQ_W 5

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define BAUD_RESET 16'h0002
`define BREAK_BASE_BITS 5'h0D
`define TIMEOUT_BITS 6'h20
`define IR_PULSE_NUM 3
`define IR_PULSE_DEN 16
`define BURST_LEVEL 3'h4

`endif

//--- rtl/uart_special_modes_core.sv
// Serial transceiver with LIN break, infrared and smart card modes, AXI4-Lite registers
// Summary of operation
// - Receive timeout sets its raw flag regardless of the timeout mask bit.
// - LIN break lasts 13 to 16 bit times by two-bit length code.
// - Smart card mode drives the transmit line as the card bit clock.
// - Infrared transmitter works even when the receive line is idle or unused.
// - Parity interrupt only when raw and masked parity flags are both set.
// - Burst DMA requests keep flowing in LIN and infrared modes.
// - FIFO flags pace transfers at every clock and baud setting except baud 0, where rx_sync stops following the receive line.
`timescale 1ns/10ps
`include "uart_special_defines.svh"
module uart_special_modes_core #(
    parameter int FIFO_DEPTH = 8,
    parameter int FIFO_AW = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial line
    input wire logic serial_receive_line,
    output logic serial_transmit_line,
    // Interrupt and DMA requests
    output logic irq,
    output logic dma_rx_single,
    output logic dma_rx_burst,
    output logic dma_tx_single,
    output logic dma_tx_burst
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        // Bus slave
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // Configuration
        logic [`CTRL_W-1:0] ctrl;
        logic [15:0] baud;
        logic [1:0] break_length_field;
        logic [`IRQ_W-1:0] interrupt_mask_reg;
        logic [`IRQ_W-1:0] raw_interrupt_status_reg;
        logic [1:0] dma_en;
        // Transmitter
        uart_special_pkg::tx_state_t tx_state;
        logic [15:0] tx_div;
        logic [4:0] tx_bits;
        logic [7:0] tx_shift;
        logic tx_par;
        logic tx_line;
        // Receiver
        uart_special_pkg::rx_state_t rx_state;
        logic [15:0] rx_div;
        logic [2:0] rx_bits;
        logic [7:0] rx_shift;
        logic rx_par;
        logic [5:0] idle_bits;
        logic rx_sync;
        // Outputs
        logic irq;
        logic [3:0] dma;
    } core_state_t;

    core_state_t st, next_st;

    // ----------------------------------------------------------------
    // FIFOs
    // ----------------------------------------------------------------
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic [7:0] tx_head, rx_head, rx_in;
    logic tx_full, tx_empty, rx_full, rx_empty;
    logic [FIFO_AW:0] tx_level, rx_level;

    uart_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) tx_fifo (
        .core_clk(core_clk), .rst(rst),
        .wr_valid(tx_push), .wr_data(st.w_data[7:0]),
        .rd_ready(tx_pop), .rd_data(tx_head),
        .full(tx_full), .empty(tx_empty), .level(tx_level)
    );

    uart_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rx_fifo (
        .core_clk(core_clk), .rst(rst),
        .wr_valid(rx_push), .wr_data(rx_in),
        .rd_ready(rx_pop), .rd_data(rx_head),
        .full(rx_full), .empty(rx_empty), .level(rx_level)
    );

    // Register read mux, used by the read path
    function automatic logic [31:0] read_word(input core_state_t s, input logic [7:0] a,
            input logic [7:0] head, input logic [4:0] fstat);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            `OFF_DATA: v = {24'h000000, head};
            `OFF_CTRL: v = {26'h0, s.ctrl};
            `OFF_BAUD: v = {16'h0000, s.baud};
            `OFF_LIN: v = {30'h0, s.break_length_field};
            `OFF_RAW: v = {27'h0, s.raw_interrupt_status_reg};
            `OFF_MASK: v = {27'h0, s.interrupt_mask_reg};
            `OFF_MASKED: v = {27'h0, s.raw_interrupt_status_reg & s.interrupt_mask_reg};
            `OFF_STATUS: v = {27'h0, fstat};
            `OFF_DMA: v = {30'h0, s.dma_en};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= `OFF_DMA);
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic wr_go, rd_go, tick_tx, tick_rx, rx_mid, enable, ir_mode;
    logic [`IRQ_W-1:0] set_bits;
    logic [15:0] half_baud, ir_width;

    always_comb begin
        next_st = st;
        set_bits = '0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        rx_in = st.rx_shift;
        enable = st.ctrl[`CTRL_EN];
        ir_mode = st.ctrl[`CTRL_IR];
        half_baud = {1'b0, st.baud[15:1]};
        ir_width = 16'((32'(st.baud) * `IR_PULSE_NUM) / `IR_PULSE_DEN);
        tick_tx = (st.tx_div == 16'h0000);
        tick_rx = (st.rx_div == 16'h0000);
        rx_mid = (st.rx_div == half_baud);

        // Write path: address and data may arrive in either order
        if (s_axi_awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        wr_go = st.aw_held && st.w_held && !st.bvalid;
        if (wr_go) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = addr_ok(st.aw_addr) ? 2'b00 : 2'b10;
            if (st.w_strb[0]) begin
                unique case (st.aw_addr)
                    `OFF_DATA: tx_push = 1'b1; // Full FIFO drops the byte
                    `OFF_CTRL: next_st.ctrl = st.w_data[`CTRL_W-1:0];
                    `OFF_BAUD: next_st.baud[7:0] = st.w_data[7:0];
                    `OFF_LIN: next_st.break_length_field = st.w_data[1:0];
                    `OFF_MASK: next_st.interrupt_mask_reg = st.w_data[`IRQ_W-1:0];
                    `OFF_DMA: next_st.dma_en = st.w_data[1:0];
                    default: ;
                endcase
            end
            if (st.w_strb[1] && st.aw_addr == `OFF_BAUD) begin
                next_st.baud[15:8] = st.w_data[15:8];
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // Read path: one-cycle arready, data in the same cycle as arready; status read clears
        next_st.arready = 1'b0;
        rd_go = s_axi_arvalid && !st.arready && !st.rvalid;
        if (rd_go) begin
            next_st.arready = 1'b1;
            next_st.rvalid = 1'b1;
            next_st.rresp = addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
            next_st.rdata = read_word(st, s_axi_araddr, rx_head,
                {tx_full, tx_empty, rx_full, rx_empty, st.tx_state != uart_special_pkg::TX_IDLE});
            if (s_axi_araddr == `OFF_DATA) begin
                rx_pop = 1'b1;
            end
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // Transmitter baud counter restarts on every state entry
        next_st.tx_div = tick_tx ? st.baud : st.tx_div - 16'h0001;
        // Smart card: line toggles each half bit as the card clock
        if (st.ctrl[`CTRL_SC] && enable) begin
            next_st.tx_line = (st.tx_div > half_baud);
        end
        unique case (st.tx_state)
            uart_special_pkg::TX_IDLE: begin
                if (!st.ctrl[`CTRL_SC]) begin
                    next_st.tx_line = 1'b1;
                end
                if (enable && st.ctrl[`CTRL_LIN] && st.ctrl[`CTRL_SEND_BREAK]) begin
                    next_st.ctrl[`CTRL_SEND_BREAK] = 1'b0;
                    next_st.tx_state = uart_special_pkg::TX_BREAK;
                    // Length 13..16 whole bits from the two-bit code
                    next_st.tx_bits = `BREAK_BASE_BITS + {3'b000, st.break_length_field};
                    next_st.tx_div = st.baud;
                    next_st.tx_line = 1'b0;
                end else if (enable && !tx_empty) begin
                    tx_pop = 1'b1;
                    next_st.tx_shift = tx_head;
                    next_st.tx_par = ^tx_head;
                    next_st.tx_state = uart_special_pkg::TX_START;
                    next_st.tx_div = st.baud;
                    set_bits[`IRQ_TX] = 1'b1;
                end
            end
            uart_special_pkg::TX_BREAK: begin
                next_st.tx_line = 1'b0;
                if (tick_tx) begin
                    next_st.tx_bits = st.tx_bits - 5'h01;
                    if (st.tx_bits == 5'h01) begin
                        next_st.tx_state = uart_special_pkg::TX_STOP;
                        next_st.tx_line = 1'b1;
                        set_bits[`IRQ_BREAK_DONE] = 1'b1;
                    end
                end
            end
            uart_special_pkg::TX_START: begin
                if (!st.ctrl[`CTRL_SC]) begin
                    // Infrared drives low while tx_div is above ir_width, then high; never looks at the receive line
                    next_st.tx_line = ir_mode ? !(st.tx_div > ir_width) : 1'b0;
                end
                if (tick_tx) begin
                    next_st.tx_state = uart_special_pkg::TX_DATA;
                    next_st.tx_bits = 5'h08;
                end
            end
            uart_special_pkg::TX_DATA: begin
                if (!st.ctrl[`CTRL_SC]) begin
                    next_st.tx_line = (ir_mode && !st.tx_shift[0]) ?
                        !(st.tx_div > ir_width) : st.tx_shift[0];
                end
                if (tick_tx) begin
                    next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
                    next_st.tx_bits = st.tx_bits - 5'h01;
                    if (st.tx_bits == 5'h01) begin
                        next_st.tx_state = st.ctrl[`CTRL_PAR] ? uart_special_pkg::TX_PARITY
                                                             : uart_special_pkg::TX_STOP;
                    end
                end
            end
            uart_special_pkg::TX_PARITY: begin
                if (!st.ctrl[`CTRL_SC]) begin
                    next_st.tx_line = st.tx_par;
                end
                if (tick_tx) begin
                    next_st.tx_state = uart_special_pkg::TX_STOP;
                end
            end
            uart_special_pkg::TX_STOP: begin
                if (!st.ctrl[`CTRL_SC]) begin
                    next_st.tx_line = 1'b1;
                end
                if (tick_tx) begin
                    next_st.tx_state = uart_special_pkg::TX_IDLE;
                end
            end
        endcase

        // Receiver: sample each bit at mid period, timeout after idle bit times
        next_st.rx_sync = serial_receive_line;
        next_st.rx_div = tick_rx ? st.baud : st.rx_div - 16'h0001;
        unique case (st.rx_state)
            uart_special_pkg::RX_IDLE: begin
                if (enable && !st.rx_sync) begin
                    next_st.rx_state = uart_special_pkg::RX_DATA;
                    next_st.rx_div = st.baud + half_baud;
                    next_st.rx_bits = 3'h0;
                    next_st.rx_par = 1'b0;
                    next_st.idle_bits = 6'h00;
                end else if (tick_rx && !rx_empty && st.idle_bits != `TIMEOUT_BITS) begin
                    next_st.idle_bits = st.idle_bits + 6'h01;
                    if (st.idle_bits == `TIMEOUT_BITS - 6'h01) begin
                        // Raw flag set independently of the mask
                        set_bits[`IRQ_TIMEOUT] = 1'b1;
                    end
                end
            end
            uart_special_pkg::RX_DATA: begin
                if (tick_rx) begin
                    next_st.rx_shift = {st.rx_sync, st.rx_shift[7:1]};
                    next_st.rx_par = st.rx_par ^ st.rx_sync;
                    next_st.rx_bits = st.rx_bits + 3'h1;
                    if (st.rx_bits == 3'h7) begin
                        next_st.rx_state = st.ctrl[`CTRL_PAR] ? uart_special_pkg::RX_PARITY
                                                             : uart_special_pkg::RX_STOP;
                    end
                end
            end
            uart_special_pkg::RX_PARITY: begin
                if (tick_rx) begin
                    next_st.rx_state = uart_special_pkg::RX_STOP;
                    // Only real mismatches flag parity; no phantom source
                    if (st.rx_par ^ st.rx_sync) begin
                        set_bits[`IRQ_PARITY] = 1'b1;
                    end
                end
            end
            uart_special_pkg::RX_STOP: begin
                if (tick_rx) begin
                    next_st.rx_state = uart_special_pkg::RX_IDLE;
                    rx_push = 1'b1; // Full FIFO drops the byte
                    set_bits[`IRQ_RX] = 1'b1;
                end
            end
        endcase
        if (rx_mid) begin
            next_st.rx_sync = st.rx_sync;
        end

        // Sticky status: read clears, new event wins over the clear
        if (rd_go && s_axi_araddr == `OFF_RAW) begin
            next_st.raw_interrupt_status_reg = '0;
        end
        next_st.raw_interrupt_status_reg = next_st.raw_interrupt_status_reg | set_bits;
        // Interrupt only from raw AND mask; reads of masked view match this exactly
        next_st.irq = |(next_st.raw_interrupt_status_reg & next_st.interrupt_mask_reg);

        // DMA requests from FIFO levels gated by the dma_en bits, independent of LIN or infrared mode
        next_st.dma[0] = st.dma_en[0] && !rx_empty;
        next_st.dma[1] = st.dma_en[0] && (rx_level >= (FIFO_AW+1)'(`BURST_LEVEL));
        next_st.dma[2] = st.dma_en[1] && !tx_full;
        next_st.dma[3] = st.dma_en[1] &&
            ((FIFO_AW+1)'(FIFO_DEPTH) - tx_level >= (FIFO_AW+1)'(`BURST_LEVEL));
    end

    // Single state register; pacing holds at every baud except 0, where rx_sync stops following the line
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            st.baud <= `BAUD_RESET;
            st.tx_line <= 1'b1;
            st.rx_sync <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign s_axi_awready = !st.aw_held;
    assign s_axi_wready = !st.w_held;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign serial_transmit_line = st.tx_line;
    assign irq = st.irq;
    assign dma_rx_single = st.dma[0];
    assign dma_rx_burst = st.dma[1];
    assign dma_tx_single = st.dma[2];
    assign dma_tx_burst = st.dma[3];
endmodule // uart_special_modes_core

//--- rtl/uart_special_pkg.sv
// Types shared by the serial core modules
package uart_special_pkg;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_BREAK,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } rx_state_t;

endpackage

//--- sim/uart_serial_peer.sv
// Serial peer that sends frames into the core's receive line
`timescale 1ns/10ps
module uart_serial_peer (
    // Clock
    input wire logic core_clk,
    // Line toward the core
    output logic line
);
    // Sits high between frames, like a pulled-up receive pin
    initial line = 1'h1;
    // Start, data LSB first, parity (or a spare stop), stop; bad flips parity
    task automatic send(input logic [7:0] d, input logic par, input logic bad, input int bt);
        logic [10:0] f;
        f = {1'h1, (par ? ((^d) ^ bad) : 1'h1), d, 1'h0};
        for (int i = 0; i < 11; i++) begin
            line <= f[i];
            repeat (bt) @(posedge core_clk);
        end
    endtask
endmodule // uart_serial_peer

//--- sim/uart_special_modes_core_sva.sv
// Port-level assertions for the serial core
`timescale 1ns/10ps
`include "uart_special_defines.svh"
module uart_special_modes_core_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line, interrupt and DMA
    input wire logic serial_transmit_line,
    input wire logic irq,
    input wire logic dma_tx_burst
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic mask_set;
    // Mask stays clear until software addresses it, so irq must stay low until then
    always_ff @(posedge core_clk) begin
        if (rst) mask_set <= 1'h0;
        else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `OFF_MASK) mask_set <= 1'h1;
    end
    sequence rd_req;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    endsequence
    sequence wr_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    irq_quiet_a:
        assert property (!mask_set |-> !irq) else $error("irq with mask clear");
    idle_line_a:
        assert property ($fell(rst) |-> serial_transmit_line && !irq) else $error("line not idle");
    dma_quiet_a:
        assert property ($fell(rst) |-> !dma_tx_burst) else $error("burst out of reset");
    rd_answer_a:
        assert property (rd_req |=> s_axi_arready && s_axi_rvalid) else $error("read late");
    ar_pulse_a:
        assert property (s_axi_arready |=> !s_axi_arready) else $error("arready too long");
    rd_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
            else $error("read data dropped");
    wr_hold_a:
        assert property (wr_wait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    wr_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid) else $error("write response late");
endmodule // uart_special_modes_core_sva
bind uart_special_modes_core uart_special_modes_core_sva u_sva (.core_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .serial_transmit_line, .irq, .dma_tx_burst);

//--- sim/uart_special_modes_core_tb.sv
// Self-checking bench for the serial core
`timescale 1ns/10ps
`include "uart_special_defines.svh"
module uart_special_modes_core_tb;
    logic core_clk = 1'h0, rst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic serial_receive_line, serial_transmit_line, irq;
    logic dma_rx_single, dma_rx_burst, dma_tx_single, dma_tx_burst;
    int miscompares = 0, n_checks = 0, cycles = 0;
    localparam int BT = `BAUD_RESET + 1;
    always #2 core_clk = ~core_clk;
    uart_special_modes_core u_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .serial_receive_line, .serial_transmit_line, .irq,
        .dma_rx_single, .dma_rx_burst, .dma_tx_single, .dma_tx_burst);
    uart_serial_peer u_peer (.core_clk, .line(serial_receive_line));
    task automatic test_done;
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Handshakes are judged at the falling edge, acted on at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        hb = 1'h0;
        while (!hb) begin
            @(negedge core_clk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid === 1'h1;
            @(posedge core_clk);
            if (ha) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
            if (hb) s_axi_bready <= 1'h0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ha, hr;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        hr = 1'h0;
        while (!hr) begin
            @(negedge core_clk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid === 1'h1;
            d = s_axi_rdata;
            @(posedge core_clk);
            if (ha) s_axi_arvalid <= 1'h0;
            if (hr) s_axi_rready <= 1'h0;
        end
    endtask
    // Waits end on a falling edge so outputs are settled when judged
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic watch(input int n, output int lows, output int flips);
        logic last;
        lows = 0;
        flips = 0;
        last = serial_transmit_line;
        repeat (n) begin
            @(negedge core_clk);
            lows += !serial_transmit_line;
            flips += serial_transmit_line != last;
            last = serial_transmit_line;
        end
    endtask
    // Every break length code, line low counted from before the request lands
    task automatic t_break;
        int lo, fl;
        for (int c = 0; c < 4; c++) begin
            wr(`OFF_LIN, c);
            fork
                wr(`OFF_CTRL, 32'h23);
                watch(90, lo, fl);
            join
            chk(lo, (13 + c) * BT);
            rd(`OFF_RAW, rdv);
            chk(rdv[`IRQ_BREAK_DONE], 1'h1);
        end
    endtask
    task automatic t_timeout;
        wr(`OFF_CTRL, 32'h1);
        u_peer.send(8'hA5, 1'h0, 1'h0, BT);
        cyc(150);
        chk(irq, 1'h0);
        rd(`OFF_RAW, rdv);
        chk(rdv & 32'h5, 32'h5);
        rd(`OFF_DATA, rdv);
        chk(rdv, 32'hA5);
        rd(8'h40, rdv);
        chk(rdv, 32'h0);
        chk(s_axi_rresp, 2'b10);
        wr(8'h40, 32'h1);
        chk(s_axi_bresp, 2'b10);
    endtask
    // Bad parity in, then a masked transmit event must not drag parity along
    task automatic t_smartcard;
        int lo, fl;
        wr(`OFF_CTRL, 32'h19);
        u_peer.send(8'h3C, 1'h1, 1'h1, BT);
        cyc(10);
        chk(irq, 1'h0);
        rd(`OFF_RAW, rdv);
        chk(rdv[`IRQ_PARITY], 1'h1);
        wr(`OFF_MASK, 32'h2);
        fork
            wr(`OFF_DATA, 32'h55);
            watch(60, lo, fl);
        join
        chk(fl >= 4, 1'h1);
        chk(irq, 1'h1);
        rd(`OFF_RAW, rdv);
        chk(rdv[`IRQ_PARITY], 1'h0);
        cyc(3);
        chk(irq, 1'h0);
        wr(`OFF_MASK, 32'h0);
    endtask
    // Receive line left idle; infrared pulses must still leave
    task automatic t_infrared;
        int lo, fl;
        wr(`OFF_BAUD, 32'hF);
        wr(`OFF_CTRL, 32'h7);
        wr(`OFF_DMA, 32'h3);
        cyc(2);
        chk({dma_tx_burst, dma_tx_single, dma_rx_burst, dma_rx_single}, 32'hD);
        fork
            wr(`OFF_DATA, 32'h0);
            watch(200, lo, fl);
        join
        chk(lo > 0, 1'h1);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        t_break();
        t_timeout();
        t_smartcard();
        t_infrared();
        test_done();
    end
    // Hang guard, well above the roughly one thousand cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
endmodule // uart_special_modes_core_tb
